// *** bench/logical_ops_datapath_asserts.sv ***
// Checker for the logical-operation datapath, bound to its top module.
// Assumes only the top module's ports and the shared opcode constants.
`timescale 1ns/1ps
`include "logic_ops_params.svh"
module logical_ops_datapath_asserts (
  input logic ref_clk,
  input logic resetn,
  input logic accepted,
  input logic [7:0] opcode,
  input logic [7:0] operand_imm,
  input logic ready,
  input logic [7:0] acc,
  input logic carry,
  input logic direct_we,
  input logic [7:0] direct_waddr
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic lg;
  logic [8:0] prev_q;
  // Bitwise family accepted this cycle
  assign lg = accepted && opcode[7:4] inside {4'h4, 4'h5, 4'h6};
  // Carry and accumulator one cycle back
  always_ff @(posedge ref_clk)
    prev_q <= {carry, acc};
  AST_ZERO_ACC: assert property (accepted && opcode == `LOP_OP_ZERO |=> acc == 8'h00)
    else $error("clear failed");
  AST_INV_ACC: assert property (accepted && opcode == `LOP_OP_INV |=> acc == ~prev_q[7:0])
    else $error("complement failed");
  AST_ROT_L: assert property (accepted && opcode == `LOP_OP_ROT_L |=> {carry, acc} ==
    {prev_q[8], prev_q[6:0], prev_q[7]}) else $error("rotate left failed");
  AST_ROT_LC: assert property (accepted && opcode == `LOP_OP_ROT_LC |=> {carry, acc} ==
    {prev_q[7:0], prev_q[8]}) else $error("rotate left carry failed");
  AST_ROT_R: assert property (accepted && opcode == `LOP_OP_ROT_R |=> {carry, acc} ==
    {prev_q[8], prev_q[0], prev_q[7:1]}) else $error("rotate right failed");
  AST_ROT_RC: assert property (accepted && opcode == `LOP_OP_ROT_RC |=> {acc, carry} ==
    prev_q) else $error("rotate right carry failed");
  AST_CARRY_KEEP: assert property (lg |=> carry == prev_q[8])
    else $error("carry changed");
  AST_DIR_ACC: assert property (lg && opcode[3:0] == `LOP_LO_DIR_ACC |=>
    direct_we && direct_waddr == $past(operand_imm)) else $error("direct write bad");
  AST_IMM_DIR: assert property (lg && opcode[3:0] == `LOP_LO_DIR_IMM |=>
    !ready && !direct_we ##1 ready && direct_we) else $error("two cycle write bad");
  cover property (lg && opcode[3:0] == `LOP_LO_DIR_IMM);
  cover property (accepted && opcode == `LOP_OP_ROT_RC);
  cover property (lg && opcode[3:0] == `LOP_LO_DIR_ACC);
endmodule // logical_ops_datapath_asserts
bind logical_ops_datapath logical_ops_datapath_asserts i_logical_ops_datapath_asserts (
  .ref_clk, .resetn, .accepted, .opcode, .operand_imm, .ready, .acc, .carry,
  .direct_we, .direct_waddr);

// *** bench/test_logical_ops_datapath.sv ***
// Self-checking bench for the logical-operation datapath.
// Assumes design and checker files are compiled before it.
`timescale 1ns/1ps
`include "logic_ops_params.svh"
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
  $display("BAD %0t got %h want %h", $time, a, b); end end
module test_logical_ops_datapath;
  logic ref_clk, resetn, issue, ready, accepted, ind_ptr_sel, carry, direct_we, acc_s, ptr_s;
  logic [7:0] opcode, operand_imm, operand_imm2, wreg_data, direct_data, indirect_data;
  logic [7:0] direct_addr, acc, direct_wdata, direct_waddr;
  logic [1:0] instr_length, len_s;
  logic [2:0] wreg_sel;
  logic [16:0] tbl [9];
  int n_mismatch, compares;
  logical_ops_datapath i_logical_ops_datapath (.ref_clk, .resetn, .issue, .opcode,
    .operand_imm, .operand_imm2, .wreg_data, .direct_data, .indirect_data, .ready,
    .accepted, .instr_length, .wreg_sel, .ind_ptr_sel, .direct_addr, .acc, .carry,
    .direct_we, .direct_wdata, .direct_waddr);
  // Presents one instruction; register and third byte get b3 as is, direct and indirect sources distinct views of it
  task automatic op_start(input logic [7:0] o, b2, b3);
    @(posedge ref_clk);
    issue <= 1'b1;
    opcode <= o;
    operand_imm <= b2;
    operand_imm2 <= b3;
    wreg_data <= b3;
    direct_data <= ~b3;
    indirect_data <= {b3[3:0], b3[7:4]};
    @(negedge ref_clk);
    acc_s = accepted;
    len_s = instr_length;
    ptr_s = ind_ptr_sel;
  endtask
  task automatic op(input logic [7:0] o, b2, b3);
    op_start(o, b2, b3);
    @(posedge ref_clk);
    issue <= 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic opc(input logic [7:0] o, b2, b3, e);
    op(o, b2, b3);
    `CHK(acc, e);
  endtask
  task automatic t_bitwise;
    opc(`LOP_OP_ZERO, 8'h00, 8'h00, 8'h00);
    opc(`LOP_OP_INV, 8'h00, 8'h00, 8'hff);
    opc(8'h5b, 8'h00, 8'h3c, 8'h3c);
    `CHK(len_s, 2'h1);
    `CHK(wreg_sel, 3'h3);
    opc(8'h45, 8'h20, 8'h41, 8'hbe);
    `CHK(len_s, 2'h2);
    `CHK(direct_addr, 8'h20);
    opc(8'h64, 8'h0f, 8'h00, 8'hb1);
    opc(8'h57, 8'h00, 8'h12, 8'h21);
    `CHK(ptr_s, 1'b1);
    opc(8'h66, 8'h00, 8'h34, 8'h62);
    `CHK(ptr_s, 1'b0);
    `CHK(acc_s, 1'b1);
    op(8'h40, 8'h00, 8'h00);
    `CHK({acc_s, carry, acc}, {2'b00, 8'h62});
  endtask
  task automatic t_direct;
    opc(8'h52, 8'h30, 8'h0f, 8'h62);
    `CHK({direct_we, direct_wdata, direct_waddr}, {1'b1, 8'h60, 8'h30});
    op_start(8'h63, 8'h31, 8'h55);
    `CHK(len_s, 2'h3);
    op_start(`LOP_OP_ZERO, 8'h00, 8'h00);
    `CHK({ready, acc_s, direct_we}, 3'b000);
    @(posedge ref_clk);
    issue <= 1'b0;
    @(negedge ref_clk);
    `CHK({direct_we, direct_wdata, direct_waddr, acc}, {1'b1, 16'hff31, 8'h62});
  endtask
  task automatic t_rotate;
    opc(`LOP_OP_ZERO, 8'h00, 8'h00, 8'h00);
    opc(8'h64, 8'h81, 8'h00, 8'h81);
    tbl = '{{8'h33, 9'h102}, {8'h03, 9'h101}, {8'hf4, 9'h1fe}, {8'h23, 9'h1fd},
      {8'he4, 9'h100}, {8'h13, 9'h080}, {8'h03, 9'h040}, {8'h23, 9'h080}, {8'h33, 9'h100}};
    foreach (tbl[i])
    begin
      op(tbl[i][16:9], 8'h00, 8'h00);
      `CHK({carry, acc}, tbl[i][8:0]);
    end
  endtask
  task automatic report_and_stop;
    if (n_mismatch == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Free-running core clock
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Watchdog against a hang
  initial
  begin
    #20000;
    n_mismatch++;
    report_and_stop();
  end
  // Reset, then each scenario in turn
  initial
  begin
    {resetn, issue, opcode, operand_imm, operand_imm2} = '0;
    {wreg_data, direct_data, indirect_data} = '0;
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    @(negedge ref_clk);
    `CHK({acc, carry, direct_we, ready}, {8'h00, 3'b001});
    t_bitwise();
    t_direct();
    t_rotate();
    report_and_stop();
  end
endmodule // test_logical_ops_datapath

// *** rtl/logic_ops_decode.sv ***
// Opcode decoder: classifies an opcode into operation, source and length.
// Assumes a full opcode byte from fetch logic on the same clock.
`timescale 1ns/1ps
`include "logic_ops_params.svh"
module logic_ops_decode (
  input wire logic [7:0] opcode,
  output logic_ops_pkg::op_kind_t op,
  output logic_ops_pkg::src_kind_t src,
  output logic to_direct,
  output logic [1:0] length,
  output logic [1:0] cycles
);
  // Combinational classification of the opcode
  always_comb
  begin
    op = logic_ops_pkg::OP_NONE;
    src = logic_ops_pkg::SRC_NONE;
    to_direct = 1'b0;
    length = 2'h1;
    cycles = 2'h1;
    case (opcode[7:4])
      `LOP_GRP_AND: op = logic_ops_pkg::OP_AND;
      `LOP_GRP_OR: op = logic_ops_pkg::OP_OR;
      `LOP_GRP_XOR: op = logic_ops_pkg::OP_XOR;
      default: op = logic_ops_pkg::OP_NONE;
    endcase
    if (op != logic_ops_pkg::OP_NONE)
    begin
      if (opcode[3])
        src = logic_ops_pkg::SRC_WREG;
      else if (opcode[3:1] == 3'h3)
        src = logic_ops_pkg::SRC_INDIRECT;
      else
      begin
        case (opcode[3:0])
          `LOP_LO_ACC_IMM:
          begin
            src = logic_ops_pkg::SRC_IMM;
            length = 2'h2;
          end
          `LOP_LO_ACC_DIR:
          begin
            src = logic_ops_pkg::SRC_DIRECT;
            length = 2'h2;
          end
          `LOP_LO_DIR_ACC:
          begin
            src = logic_ops_pkg::SRC_ACC;
            to_direct = 1'b1;
            length = 2'h2;
          end
          `LOP_LO_DIR_IMM:
          begin
            src = logic_ops_pkg::SRC_IMM;
            to_direct = 1'b1;
            length = 2'h3;
            cycles = `LOP_IMM_DIR_CYCLES;
          end
          default: op = logic_ops_pkg::OP_NONE;
        endcase
      end
    end
    else
    begin
      case (opcode)
        `LOP_OP_ZERO: op = logic_ops_pkg::OP_ZERO;
        `LOP_OP_INV: op = logic_ops_pkg::OP_INV;
        `LOP_OP_ROT_R, `LOP_OP_ROT_RC, `LOP_OP_ROT_L, `LOP_OP_ROT_LC: op = logic_ops_pkg::OP_ROT;
        default: op = logic_ops_pkg::OP_NONE;
      endcase
    end
  end
endmodule // logic_ops_decode

// *** rtl/logic_ops_params.svh ***
// Constants for the logical-operation datapath: opcodes, cycle counts, resets.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef LOGIC_OPS_PARAMS_SVH
`define LOGIC_OPS_PARAMS_SVH
// Opcode groups: upper nibble selects the operation
`define LOP_GRP_OR 4'h4
`define LOP_GRP_AND 4'h5
`define LOP_GRP_XOR 4'h6
// Lower-nibble addressing forms
`define LOP_LO_DIR_ACC 4'h2
`define LOP_LO_DIR_IMM 4'h3
`define LOP_LO_ACC_IMM 4'h4
`define LOP_LO_ACC_DIR 4'h5
// Single-operand accumulator opcodes
`define LOP_OP_ROT_R 8'h03
`define LOP_OP_ROT_RC 8'h13
`define LOP_OP_ROT_L 8'h23
`define LOP_OP_ROT_LC 8'h33
`define LOP_OP_ZERO 8'he4
`define LOP_OP_INV 8'hf4
// Reset values
`define LOP_ACC_RESET 8'h00
`define LOP_CY_RESET 1'b0
`define LOP_WE_RESET 1'b0
`define LOP_WB_RESET 8'h00
// Machine cycles for the immediate-to-direct form
`define LOP_IMM_DIR_CYCLES 2'h2
`endif

// *** rtl/logic_ops_pkg.sv ***
// Types for the logical-operation datapath.
// Assumes nothing beyond a SystemVerilog compiler.
package logic_ops_pkg;
  typedef enum logic [2:0] {
    OP_NONE, OP_AND, OP_OR, OP_XOR, OP_ZERO, OP_INV, OP_ROT
  } op_kind_t;
  typedef enum logic [2:0] {
    SRC_NONE, SRC_WREG, SRC_DIRECT, SRC_INDIRECT, SRC_IMM, SRC_ACC
  } src_kind_t;
  typedef enum logic {ST_IDLE, ST_WRITE} seq_state_t;
endpackage

// *** rtl/logical_ops_datapath.sv ***
// Logical-operation datapath: accumulator, carry and direct-byte write-back.
// Assumes core fetch logic presents opcode, operand bytes and operand data,
// all on ref_clk; one issue pulse per machine cycle when ready is high.
// Direct operands are taken as they stand in the issue cycle; a store still
// in flight here must be forwarded by the core itself.
//
// What this block does
// - AND accumulator with register, direct, indirect or immediate into accumulator
// - OR accumulator with register, direct, indirect or immediate into accumulator
// - XOR accumulator with register, direct, indirect or immediate into accumulator
// - AND/OR/XOR accumulator into a direct byte, writing that byte back
// - Immediate into direct byte: three bytes, two machine cycles, write back
// - Register or indirect forms one byte; direct or immediate to accumulator two
// - Clear forces accumulator to zero, one byte, one cycle
// - Complement inverts every accumulator bit, one byte, one cycle
// - Rotate left, top bit to bit zero, carry untouched
// - Rotate left via carry as a nine-bit ring
// - Rotate right, bit zero to top bit, carry untouched
// - Rotate right via carry: bit zero to carry, carry to top bit
// - Indirect source is RAM addressed by working register zero or one
// - Immediate operand is the 8-bit byte following the opcode; for immediate into direct byte, the third byte
`timescale 1ns/1ps
`include "logic_ops_params.svh"
module logical_ops_datapath (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic issue,
  input wire logic [7:0] opcode,
  input wire logic [7:0] operand_imm,
  input wire logic [7:0] operand_imm2,
  input wire logic [7:0] wreg_data,
  input wire logic [7:0] direct_data,
  input wire logic [7:0] indirect_data,
  output logic ready,
  output logic accepted,
  output logic [1:0] instr_length,
  output logic [2:0] wreg_sel,
  output logic ind_ptr_sel,
  output logic [7:0] direct_addr,
  output logic [7:0] acc,
  output logic carry,
  output logic direct_we,
  output logic [7:0] direct_wdata,
  output logic [7:0] direct_waddr
);
  // Decoded view of the presented opcode
  logic_ops_pkg::op_kind_t op;
  logic_ops_pkg::src_kind_t src;
  logic to_direct;
  logic [1:0] length;
  logic [1:0] cycles;

  // Architectural state and its next values
  logic_ops_pkg::seq_state_t state_q;
  logic [7:0] acc_q;
  logic cy_q;
  logic [7:0] acc_d;
  logic cy_d;

  // Datapath and direct-byte write-back
  logic [7:0] operand;
  logic [7:0] bitwise;
  logic [7:0] result_q;
  logic [7:0] waddr_q;
  logic we_q;
  logic take;

  // Opcode classification shared by operand mux, sequencer and length output
  logic_ops_decode i_logic_ops_decode (
    .opcode(opcode),
    .op(op),
    .src(src),
    .to_direct(to_direct),
    .length(length),
    .cycles(cycles)
  );

  // Handshake: a second cycle of immediate-to-direct blocks new issue
  assign ready = (state_q == logic_ops_pkg::ST_IDLE);
  assign take = issue && ready && (op != logic_ops_pkg::OP_NONE);
  assign accepted = take;

  // Byte count of the presented instruction, for the fetch logic
  assign instr_length = length;

  // Register-file select and indirect pointer select, straight from the opcode
  assign wreg_sel = opcode[2:0];
  assign ind_ptr_sel = opcode[0];

  // Direct address is the second instruction byte
  assign direct_addr = operand_imm;

  // Operand selection
  always_comb
  begin
    case (src)
      logic_ops_pkg::SRC_WREG: operand = wreg_data;
      logic_ops_pkg::SRC_DIRECT: operand = direct_data;
      logic_ops_pkg::SRC_INDIRECT: operand = indirect_data;
      logic_ops_pkg::SRC_IMM: operand = to_direct ? operand_imm2 : operand_imm;
      logic_ops_pkg::SRC_ACC: operand = acc_q;
      default: operand = 8'h00;
    endcase
  end

  // Bitwise combine; direct destinations combine with the byte read back,
  // so the second operand is then the accumulator, or the third byte for immediate-to-direct
  always_comb
  begin
    logic [7:0] left;
    left = to_direct ? direct_data : acc_q;
    case (op)
      logic_ops_pkg::OP_AND: bitwise = left & operand;
      logic_ops_pkg::OP_OR: bitwise = left | operand;
      logic_ops_pkg::OP_XOR: bitwise = left ^ operand;
      default: bitwise = left;
    endcase
  end

  // Next accumulator value for every recognised operation
  always_comb
  begin
    acc_d = acc_q;
    case (op)
      logic_ops_pkg::OP_AND, logic_ops_pkg::OP_OR, logic_ops_pkg::OP_XOR:
        if (!to_direct)
          acc_d = bitwise;
      logic_ops_pkg::OP_ZERO: acc_d = 8'h00;
      logic_ops_pkg::OP_INV: acc_d = ~acc_q;
      logic_ops_pkg::OP_ROT:
      begin
        case (opcode)
          `LOP_OP_ROT_L: acc_d = {acc_q[6:0], acc_q[7]};
          `LOP_OP_ROT_LC: acc_d = {acc_q[6:0], cy_q};
          `LOP_OP_ROT_R: acc_d = {acc_q[0], acc_q[7:1]};
          `LOP_OP_ROT_RC: acc_d = {cy_q, acc_q[7:1]};
          default: acc_d = acc_q;
        endcase
      end
      default: acc_d = acc_q;
    endcase
  end

  // Next carry; the bitwise group, clear and complement never reach it
  always_comb
  begin
    cy_d = cy_q;
    case (opcode)
      `LOP_OP_ROT_LC: cy_d = acc_q[7];
      `LOP_OP_ROT_RC: cy_d = acc_q[0];
      default: cy_d = cy_q;
    endcase
  end

  // Accumulator, loaded at the edge that takes the instruction
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      acc_q <= `LOP_ACC_RESET;
    else if (take)
      acc_q <= acc_d;
  end

  // Carry flag, loaded alongside the accumulator
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      cy_q <= `LOP_CY_RESET;
    else if (take)
      cy_q <= cy_d;
  end

  // Two-cycle sequencer for the immediate-to-direct form; its second cycle
  // refuses new issue so the store gets a cycle of its own
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      state_q <= logic_ops_pkg::ST_IDLE;
    else
    begin
      case (state_q)
        logic_ops_pkg::ST_IDLE:
          if (take && cycles == `LOP_IMM_DIR_CYCLES)
            state_q <= logic_ops_pkg::ST_WRITE;
        logic_ops_pkg::ST_WRITE: state_q <= logic_ops_pkg::ST_IDLE;
        default: state_q <= logic_ops_pkg::ST_IDLE;
      endcase
    end
  end

  // Write strobe: next cycle for an accumulator source, after the stall otherwise
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      we_q <= `LOP_WE_RESET;
    else if (state_q == logic_ops_pkg::ST_WRITE)
      we_q <= 1'b1;
    else
      we_q <= take && to_direct && (cycles != `LOP_IMM_DIR_CYCLES);
  end

  // Stored byte and its address, held until the next direct store
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      result_q <= `LOP_WB_RESET;
      waddr_q <= `LOP_WB_RESET;
    end
    else if (take && to_direct)
    begin
      result_q <= bitwise;
      waddr_q <= operand_imm;
    end
  end

  // Outputs straight from their registers
  assign acc = acc_q;
  assign carry = cy_q;
  assign direct_we = we_q;
  assign direct_wdata = result_q;
  assign direct_waddr = waddr_q;
endmodule // logical_ops_datapath
